// ===== hw/common_mode_control.sv
// Common mode register with host bus front end and buffer access gating
`timescale 1ns/100ps

module common_mode_control
(
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire common_mode_pkg::bus_pins_t   bus_pins,
    output logic      [7:0]                   host_rdata_out,
    output logic                              host_rdata_oe,
    output common_mode_pkg::mem_req_t         mem_req,
    input  wire logic [7:0]                   mem_rdata,
    output common_mode_pkg::mode_bits_t       mode_bits,
    output logic                              soft_reset_pulse
);

    localparam int PIN_W = $bits(common_mode_pkg::bus_pins_t);

    // Whole state of the block
    typedef struct packed {
        logic [7:0]                 mode;              // Stored mode register
        logic [14:0]                pointer;           // Indirect pointer
        common_mode_pkg::acc_state_t acc;              // Access sequencer
        logic                       wr_seen;           // Write strobe already taken
        logic [7:0]                 rdata;             // Data for the pins
        logic                       step_after_read;   // Step pointer on capture
        common_mode_pkg::mem_req_t  req;               // Request to memory
        logic                       soft_reset;        // Soft reset pulse
    } ctrl_state_t;

    ctrl_state_t                state_reg;
    ctrl_state_t                state_next;
    common_mode_pkg::bus_pins_t pins;                  // Synchronised pins

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, strobes idle high
    pin_sync
    #(
        .W           (PIN_W),
        .RESET_VALUE ({3'b111, {(PIN_W - 3){1'b0}}})
    )
    u_pin_sync
    (
        .clock     (clock),
        .resetn    (resetn),
        .pin_in    (bus_pins),
        .level_out (pins)
    );

    // Decoded access view
    logic        selected;                             // Chip selected
    logic        rd_act;                               // Read in progress
    logic        wr_act;                               // Write in progress
    logic        indirect;                             // Indirect access on
    logic        little;                               // Little-endian pointer
    logic        stepping;                             // Auto-step active
    logic        is_mode;                          // Access hits mode register
    logic        is_ptr_hi;                            // Access hits pointer high
    logic        is_ptr_lo;                            // Access hits pointer low
    logic        is_data;                              // Access reaches memory
    logic [14:0] target;                               // Memory address
    logic        in_tx;                                // Target in transmit buffer
    logic        in_rx;                                // Target in receive buffer
    logic        selftest;                             // Buffer self-test on

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode in direct and indirect mode
    always_comb
    begin
        selected = !pins.cs_n;
        rd_act   = selected && !pins.rd_n;
        wr_act   = selected && !pins.wr_n;
        selftest = state_reg.mode[common_mode_pkg::SELFTEST_BIT];
        indirect = state_reg.mode[common_mode_pkg::WINDOW_BIT];
        // Order and step only count in indirect mode
        little   = indirect && state_reg.mode[common_mode_pkg::BYTE_ORDER_BIT];
        stepping = indirect && state_reg.mode[common_mode_pkg::STEP_BIT];
        is_ptr_hi = 1'b0;
        is_ptr_lo = 1'b0;
        if (indirect)
        begin
            // Slot decode, byte order swaps the pointer slots
            is_mode   = pins.addr[1:0] == common_mode_pkg::SLOT_MODE;
            is_data   = pins.addr[1:0] == common_mode_pkg::SLOT_DATA;
            target    = state_reg.pointer;
            if (pins.addr[1:0] == common_mode_pkg::SLOT_PTR_A)
            begin
                is_ptr_hi = !little;
                is_ptr_lo = little;
            end
            else if (pins.addr[1:0] == common_mode_pkg::SLOT_PTR_B)
            begin
                is_ptr_hi = little;
                is_ptr_lo = !little;
            end
        end
        else
        begin
            // Direct decode on the full address
            is_mode = pins.addr == common_mode_pkg::MODE_OFFSET;
            is_data = !is_mode;
            target  = pins.addr;
        end
        in_tx = target >= common_mode_pkg::TX_BASE && target <= common_mode_pkg::TX_LAST;
        in_rx = target >= common_mode_pkg::RX_BASE && target <= common_mode_pkg::RX_LAST;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: writes, read sequencing, pointer stepping, soft reset
    always_comb
    begin
        state_next            = state_reg;
        state_next.req.we     = 1'b0;
        state_next.req.re     = 1'b0;
        state_next.soft_reset = 1'b0;
        state_next.wr_seen    = wr_act;

        // Write taken once per strobe
        if (wr_act && !state_reg.wr_seen)
        begin
            if (is_mode)
            begin
                // Reserved bit dropped, soft reset bit never stored
                state_next.mode = pins.wdata & common_mode_pkg::MODE_WRITE_MASK;
            end
            else if (is_ptr_hi)
            begin
                state_next.pointer[14:8] = pins.wdata[6:0];
            end
            else if (is_ptr_lo)
            begin
                state_next.pointer[7:0] = pins.wdata;
            end
            else if (is_data)
            begin
                // Receive buffer refuses writes outside self-test
                state_next.req.addr  = target;
                state_next.req.wdata = pins.wdata;
                state_next.req.we    = !in_rx || selftest;
                if (stepping)
                begin
                    state_next.pointer = state_reg.pointer
                                         + common_mode_pkg::POINTER_STEP;
                end
            end
        end

        // Read sequencer
        case (state_reg.acc)
            common_mode_pkg::ACC_IDLE:
            begin
                if (rd_act)
                begin
                    state_next.acc = common_mode_pkg::ACC_HOLD;
                    if (is_mode)
                    begin
                        state_next.rdata = state_reg.mode;
                    end
                    else if (is_ptr_hi)
                    begin
                        state_next.rdata = {1'b0, state_reg.pointer[14:8]};
                    end
                    else if (is_ptr_lo)
                    begin
                        state_next.rdata = state_reg.pointer[7:0];
                    end
                    else if (in_tx && !selftest)
                    begin
                        // Transmit buffer refuses reads outside self-test
                        state_next.rdata = common_mode_pkg::BLOCKED_READ;
                        // A refused read is still a host read, so it steps too
                        if (stepping)
                        begin
                            state_next.pointer = state_reg.pointer
                                                 + common_mode_pkg::POINTER_STEP;
                        end
                    end
                    else
                    begin
                        // Fetch from memory, stepping once the byte is in
                        state_next.acc             = common_mode_pkg::ACC_FETCH;
                        state_next.req.addr        = target;
                        state_next.req.re          = 1'b1;
                        state_next.step_after_read = stepping;
                    end
                end
            end
            common_mode_pkg::ACC_FETCH:
            begin
                // Memory answers in the same cycle as the read pulse
                state_next.rdata = mem_rdata;
                state_next.acc   = common_mode_pkg::ACC_HOLD;
                if (state_reg.step_after_read)
                begin
                    state_next.pointer = state_reg.pointer
                                         + common_mode_pkg::POINTER_STEP;
                end
            end
            common_mode_pkg::ACC_HOLD:
            begin
                // Hold data until the strobe ends
                if (!rd_act)
                begin
                    state_next.acc = common_mode_pkg::ACC_IDLE;
                end
            end
            default:
            begin
                state_next.acc = common_mode_pkg::ACC_IDLE;
            end
        endcase

        // Soft reset returns the state to reset values, except wr_seen kept set and the soft reset pulse raised
        if (wr_act && !state_reg.wr_seen && is_mode
            && pins.wdata[common_mode_pkg::SOFT_RESET_BIT])
        begin
            state_next            = '0;
            state_next.mode       = common_mode_pkg::MODE_RESET;
            state_next.pointer    = common_mode_pkg::POINTER_RESET;
            state_next.acc        = common_mode_pkg::ACC_IDLE;
            state_next.wr_seen    = 1'b1;
            state_next.soft_reset = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg         <= '0;
            state_reg.mode    <= common_mode_pkg::MODE_RESET;
            state_reg.pointer <= common_mode_pkg::POINTER_RESET;
            state_reg.acc     <= common_mode_pkg::ACC_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign host_rdata_out   = state_reg.rdata;
    assign host_rdata_oe    = state_reg.acc == common_mode_pkg::ACC_HOLD;
    assign mem_req          = state_reg.req;
    assign soft_reset_pulse = state_reg.soft_reset;

    // Mode levels to the rest of the device
    always_comb
    begin
        mode_bits.buffer_selftest_enable = state_reg.mode[common_mode_pkg::SELFTEST_BIT];
        mode_bits.echo_reply_block       =
            state_reg.mode[common_mode_pkg::ECHO_BLOCK_BIT];
        mode_bits.pppoe_enable           = state_reg.mode[common_mode_pkg::PPPOE_BIT];
        mode_bits.pointer_byte_order     = little;
        mode_bits.address_step_enable    = stepping;
        mode_bits.register_window_access_select = indirect;
    end

endmodule

// ===== hw/common_mode_pkg.sv
// Package holding constants and carrier types for the common mode register block
package common_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W = 15;                        // Host address width
    localparam int DATA_W = 8;                         // Host data width

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register location, reset and fields
    localparam logic [14:0] MODE_OFFSET     = 15'h0000; // Mode register address
    localparam logic [7:0]  MODE_RESET      = 8'h00;    // Mode register reset value
    localparam logic [7:0]  MODE_WRITE_MASK = 8'h3f;    // Bits that store a value
    localparam int SOFT_RESET_BIT  = 7;                // Self-clearing soft reset
    localparam int RESERVED_BIT    = 6;                // Reads zero
    localparam int SELFTEST_BIT    = 5;                // Buffer self-test
    localparam int ECHO_BLOCK_BIT  = 4;                // Ping reply suppression
    localparam int PPPOE_BIT       = 3;                // PPPoE enable
    localparam int BYTE_ORDER_BIT  = 2;                // Pointer byte order
    localparam int STEP_BIT        = 1;                // Pointer auto-step
    localparam int WINDOW_BIT      = 0;                // Indirect access select

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer regions and pointer reset
    localparam logic [14:0] TX_BASE       = 15'h4000; // Transmit buffer first byte
    localparam logic [14:0] TX_LAST       = 15'h5fff; // Transmit buffer last byte
    localparam logic [14:0] RX_BASE       = 15'h6000; // Receive buffer first byte
    localparam logic [14:0] RX_LAST       = 15'h7fff; // Receive buffer last byte
    localparam logic [14:0] POINTER_RESET = 15'h0000; // Indirect pointer reset
    localparam logic [14:0] POINTER_STEP  = 15'h0001; // Auto-step amount
    localparam logic [7:0]  BLOCKED_READ  = 8'h00;    // Answer for refused reads

    ////////////////////////////////////////////////////////////////////////////////
    // Indirect mode slots on the two low address lines
    localparam logic [1:0] SLOT_MODE   = 2'h0;        // Mode register
    localparam logic [1:0] SLOT_PTR_A  = 2'h1;        // Pointer high (big-endian)
    localparam logic [1:0] SLOT_PTR_B  = 2'h2;        // Pointer low (big-endian)
    localparam logic [1:0] SLOT_DATA   = 2'h3;        // Data window

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic        cs_n;                             // Chip select, active low
        logic        rd_n;                             // Read strobe, active low
        logic        wr_n;                             // Write strobe, active low
        logic [14:0] addr;                             // Address lines
        logic [7:0]  wdata;                            // Data lines in
    } bus_pins_t;

    typedef struct packed {
        logic [14:0] addr;                             // Internal byte address
        logic [7:0]  wdata;                            // Write byte
        logic        we;                               // One-cycle write pulse
        logic        re;                               // One-cycle read pulse
    } mem_req_t;

    typedef struct packed {
        logic buffer_selftest_enable;                  // Both buffers open
        logic echo_reply_block;                        // No ping replies
        logic pppoe_enable;                            // PPPoE operation
        logic pointer_byte_order;                      // 1 little-endian
        logic address_step_enable;                     // Pointer auto-step
        logic register_window_access_select;           // Indirect access on
    } mode_bits_t;

    // Host access sequencer states
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,                            // Waiting for a strobe
        ACC_FETCH = 3'b010,                            // Read data due from memory
        ACC_HOLD  = 3'b100                             // Driving read data
    } acc_state_t;

endpackage

// ===== hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module pin_sync
#(
    parameter int         W          = 1,
    parameter logic [W-1:0] RESET_VALUE = '0
)
(
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);

    // All stages of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;                              // Metastability catcher
        logic [W-1:0] s2;                              // Second stage
        logic [W-1:0] s3;                              // Third stage
        logic [W-1:0] level;                           // Agreed value
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift and accept a change once stages two and three agree
    always_comb
    begin
        state_next    = state_reg;
        state_next.s1 = pin_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < W; i++)
        begin
            // Bits that agree are taken
            if (state_reg.s2[i] == state_reg.s3[i])
            begin
                state_next.level[i] = state_reg.s3[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= {4{RESET_VALUE}};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.level;

endmodule

// ===== tb/common_mode_control_props.sv
// Port-level assertions for the common mode register block
`timescale 1ns/100ps
module common_mode_control_props
(
    input wire logic                        clock,
    input wire logic                        resetn,
    input wire common_mode_pkg::bus_pins_t  bus_pins,
    input wire logic [7:0]                  host_rdata_out,
    input wire logic                        host_rdata_oe,
    input wire common_mode_pkg::mem_req_t   mem_req,
    input wire logic [7:0]                  mem_rdata,
    input wire common_mode_pkg::mode_bits_t mode_bits,
    input wire logic                        soft_reset_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Read issue and its answer on the data pins
    sequence s_mem_read;
        mem_req.re;
    endsequence
    sequence s_pin_answer;
        ##1 host_rdata_oe;
    endsequence
    a_read_answer: assert property (s_mem_read |-> s_pin_answer)
        else $error("memory read not answered on the pins");
    a_tx_read_refused: assert property (mem_req.re && mem_req.addr >= common_mode_pkg::TX_BASE
        && mem_req.addr <= common_mode_pkg::TX_LAST |-> mode_bits.buffer_selftest_enable)
        else $error("transmit buffer read without self-test");
    a_rx_write_refused: assert property (mem_req.we && mem_req.addr >= common_mode_pkg::RX_BASE
        |-> mode_bits.buffer_selftest_enable)
        else $error("receive buffer write without self-test");
    a_write_pulse_single: assert property (mem_req.we |=> !mem_req.we)
        else $error("write pulse longer than one cycle");
    a_soft_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    a_soft_clears_mode: assert property (soft_reset_pulse |-> ##[0:1] (mode_bits == '0))
        else $error("mode not cleared by soft reset");
    a_gated_order: assert property (!mode_bits.register_window_access_select
        |-> !mode_bits.pointer_byte_order && !mode_bits.address_step_enable)
        else $error("pointer options active outside indirect mode");
    a_mode_needs_write: assert property ($changed(mode_bits)
        |-> !bus_pins.wr_n && !bus_pins.cs_n)
        else $error("mode changed without a host write");
    a_oe_release: assert property ($rose(bus_pins.rd_n) |-> ##[1:6] !host_rdata_oe)
        else $error("data pins still driven after read strobe");
    a_access_selected: assert property ((mem_req.we || mem_req.re) |-> !bus_pins.cs_n)
        else $error("buffer access without chip select");
endmodule

// ===== tb/buffer_mem_model.sv
// Behavioural byte memory standing behind the block's buffer port
`timescale 1ns/100ps
module buffer_mem_model
(
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire common_mode_pkg::mem_req_t mem_req,
    output logic [7:0]                     mem_rdata
);
    logic [7:0] mem [0:32767];   // Byte store, cleared at start
    logic       window_reg;      // Read data still owed
    logic [7:0] filler_reg;      // Changing value outside reads
    initial foreach (mem[i]) mem[i] = 8'h00;
    // Store writes, track read window, churn filler
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            window_reg <= 1'b0;
            filler_reg <= 8'h5a;
        end
        else
        begin
            window_reg <= mem_req.re;
            filler_reg <= ~filler_reg + 8'h01;
            if (mem_req.we)
                mem[mem_req.addr] <= mem_req.wdata;
        end
    end
    // Data valid through the read and the cycle after it
    assign mem_rdata = (mem_req.re || window_reg) ? mem[mem_req.addr] : filler_reg;
endmodule

// ===== tb/common_mode_control_tb.sv
// Self-checking bench for the common mode register block
`timescale 1ns/100ps
module common_mode_control_tb;
    common_mode_pkg::bus_pins_t   bus_pins;         // Host pins
    common_mode_pkg::mem_req_t    mem_req;          // Buffer requests
    common_mode_pkg::mode_bits_t  mode_bits;        // Decoded mode
    logic                         clock;            // System clock
    logic                         resetn;           // Hardware reset
    logic [7:0]                   host_rdata_out;   // Read data
    logic                         host_rdata_oe;    // Data pin drive
    logic [7:0]                   mem_rdata;        // Memory answer
    logic                         soft_reset_pulse; // Soft reset seen
    logic [7:0]                   rd;               // Last read byte
    int fails, samples_checked, cycles, we_cnt, re_cnt, soft_cnt, k;

    common_mode_control common_mode_control_i (.clock(clock), .resetn(resetn),
        .bus_pins(bus_pins), .host_rdata_out(host_rdata_out), .host_rdata_oe(host_rdata_oe),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .mode_bits(mode_bits),
        .soft_reset_pulse(soft_reset_pulse));
    buffer_mem_model buffer_mem_model_i (.clock(clock), .resetn(resetn), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Pulse counters and hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (mem_req.we === 1'b1) we_cnt++;
        if (mem_req.re === 1'b1) re_cnt++;
        if (soft_reset_pulse === 1'b1) soft_cnt++;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Host bus cycles, address and data settle before the strobe
    task automatic bus_write(input logic [14:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_pins.cs_n <= 1'b0;
        bus_pins.addr <= a;
        bus_pins.wdata <= d;
        repeat (5) @(posedge clock);
        bus_pins.wr_n <= 1'b0;
        repeat (10) @(posedge clock);
        bus_pins.wr_n <= 1'b1;
        bus_pins.cs_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
    task automatic bus_read(input logic [14:0] a, output logic [7:0] d);
        int n;
        @(posedge clock);
        bus_pins.cs_n <= 1'b0;
        bus_pins.addr <= a;
        repeat (5) @(posedge clock);
        bus_pins.rd_n <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (host_rdata_oe !== 1'b1 && n < 20);
        check_count(int'(n < 20), 1, "read answer");
        d = host_rdata_out;
        @(posedge clock);
        bus_pins.rd_n <= 1'b1;
        bus_pins.cs_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons and closing
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic check_mode(input common_mode_pkg::mode_bits_t exp);
        check_byte({2'b00, mode_bits}, {2'b00, exp}, "mode bits");
    endtask
    task automatic check_count(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, m, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        bus_pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 15'h0000, wdata: 8'h00};
        resetn = 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(posedge clock);
        bus_read(common_mode_pkg::MODE_OFFSET, rd);
        check_byte(rd, common_mode_pkg::MODE_RESET, "mode reset");
        check_mode('0);
        $display("test reset done");
        bus_write(15'h0000, 8'h7e);
        bus_read(15'h0000, rd);
        check_byte(rd, 8'h3e, "reserved bit");
        check_mode(6'h38);
        k = soft_cnt;
        bus_write(15'h0000, 8'h80);
        check_count(int'(soft_cnt > k), 1, "soft pulse");
        bus_read(15'h0000, rd);
        check_byte(rd, 8'h00, "soft reset");
        $display("test mode fields done");
        bus_write(15'h0000, 8'h20);
        k = we_cnt;
        bus_write(15'h4000, 8'ha5);
        bus_write(15'h6001, 8'h5a);
        check_count(we_cnt - k, 2, "self-test writes");
        k = re_cnt;
        bus_read(15'h4000, rd);
        check_byte(rd, 8'ha5, "self-test tx read");
        bus_read(15'h6001, rd);
        check_byte(rd, 8'h5a, "self-test rx read");
        check_count(re_cnt - k, 2, "self-test reads");
        bus_write(15'h0000, 8'h00);
        k = we_cnt;
        bus_write(15'h4001, 8'h11);
        bus_write(15'h6001, 8'h77);
        check_count(we_cnt - k, 1, "normal writes");
        check_byte(buffer_mem_model_i.mem[15'h4001], 8'h11, "tx write");
        k = re_cnt;
        bus_read(15'h4000, rd);
        check_byte(rd, common_mode_pkg::BLOCKED_READ, "tx read");
        bus_read(15'h6001, rd);
        check_byte(rd, 8'h5a, "rx read");
        check_count(re_cnt - k, 1, "normal reads");
        $display("test buffers done");
        bus_write(15'h0000, 8'h03);
        check_mode(6'h03);
        bus_write(15'h0001, 8'h40);
        bus_write(15'h0002, 8'h10);
        bus_write(15'h0003, 8'hc1);
        bus_write(15'h0003, 8'hc2);
        check_byte(buffer_mem_model_i.mem[15'h4010], 8'hc1, "step write");
        check_byte(buffer_mem_model_i.mem[15'h4011], 8'hc2, "step write");
        bus_read(15'h0002, rd);
        check_byte(rd, 8'h12, "pointer low");
        bus_read(15'h0001, rd);
        check_byte(rd, 8'h40, "pointer high");
        bus_write(15'h0000, 8'h23);
        bus_write(15'h0002, 8'h10);
        bus_read(15'h0003, rd);
        check_byte(rd, 8'hc1, "window read");
        bus_read(15'h0002, rd);
        check_byte(rd, 8'h11, "read step");
        bus_write(15'h0000, 8'h05);
        check_mode(6'h05);
        bus_write(15'h0001, 8'h34);
        bus_write(15'h0002, 8'h41);
        bus_write(15'h0003, 8'h5c);
        bus_write(15'h0003, 8'h5d);
        check_byte(buffer_mem_model_i.mem[15'h4134], 8'h5d, "no step");
        check_byte(buffer_mem_model_i.mem[15'h4135], 8'h00, "no step");
        bus_read(15'h0001, rd);
        check_byte(rd, 8'h34, "little low");
        bus_read(15'h0002, rd);
        check_byte(rd, 8'h41, "little high");
        bus_write(15'h0000, 8'h00);
        check_mode('0);
        $display("test indirect done");
        end_of_test();
    end
endmodule

bind common_mode_control common_mode_control_props common_mode_control_props_i (
    .clock(clock), .resetn(resetn), .bus_pins(bus_pins), .host_rdata_out(host_rdata_out),
    .host_rdata_oe(host_rdata_oe), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mode_bits(mode_bits), .soft_reset_pulse(soft_reset_pulse));
